// ==== ssr_status_bank.sv ====
// System status readback, reset cause capture and watchdog period control
`timescale 1ns/10ps
module ssr_status_bank #(
  parameter int OSC_DIV = ssr_pkg::OSC_DIV,
  parameter int RST_PULSE_CYC = ssr_pkg::RST_PULSE_CYC
) (
  input wire logic clk,
  input wire logic system_reset_output,
  input wire logic frame_valid,
  input wire logic [ssr_pkg::FRAME_W-1:0] frame_data,
  input wire logic [1:0] op_mode,
  input wire logic [1:0] watchdog_prescale_select,
  input wire logic supply_current_reset_option,
  input wire logic por_event,
  input wire logic ext_reset_event,
  input wire logic cyclic_wake_event,
  input wire logic v1_low_event,
  input wire logic v1_overcurrent_event,
  input wire logic v3_overload_event,
  input wire logic flash_exit_event,
  input wire logic flash_ready_event,
  input wire logic bus_wake_event,
  input wire logic local_wake_event,
  input wire logic failsafe_wake_event,
  input wire logic wd_init_miss_event,
  input wire logic wd_early_event,
  input wire logic spi_illegal_event,
  input wire logic int_timeout_event,
  output logic [ssr_pkg::FRAME_W-1:0] status_word,
  output logic status_valid,
  output logic [5:0] nominal_period_code,
  output logic [3:0] reset_cause_code,
  output logic system_reset_output_n,
  output logic mcu_supply_output
);
  generate
    if (RST_PULSE_CYC < 1 || RST_PULSE_CYC >= (1 << ssr_pkg::RST_CNT_W)) begin : g_chk
      $error("RST_PULSE_CYC out of range");
    end
  endgenerate

  typedef struct packed {
    logic [ssr_pkg::MODE_W-1:0] mode_reg;
    logic [3:0] cause;
    logic [ssr_pkg::FRAME_W-1:0] status_word;
    logic status_valid;
    ssr_pkg::ssr_sleep_t sleep_st;
    logic [ssr_pkg::RST_CNT_W-1:0] rst_cnt;
    logic reset_n;
    logic supply;
    logic wd_restart;
  } ssr_state_t;

  ssr_state_t s;
  ssr_state_t next_s;

  logic hdr_ok;
  logic is_sleep;
  logic [ssr_pkg::N_EVT-1:0] ev;
  logic [ssr_pkg::PER_W-1:0] period_ms;
  logic period_known;
  logic wd_off;
  logic wd_enable;
  logic wd_overflow;

  // Status frame header; no mode term here, so reads work in every mode
  assign hdr_ok = (frame_data[ssr_pkg::ADDR_HI:ssr_pkg::ADDR_LO] == ssr_pkg::ADDR_STATUS)
    && !frame_data[ssr_pkg::RRS_BIT];
  assign is_sleep = (op_mode == ssr_pkg::OP_SLEEP);

  ssr_period_lut u_lut (
    .code(s.mode_reg[ssr_pkg::NPC_HI:ssr_pkg::NPC_LO]),
    .op_mode(op_mode),
    .prescale(watchdog_prescale_select),
    .period_ms(period_ms),
    .known(period_known),
    .wd_off(wd_off)
  );

  // Off code stops the counter in the same cycle the mode changes
  assign wd_enable = period_known && !wd_off && (s.rst_cnt == '0);

  ssr_wd_timer #(
    .OSC_DIV(OSC_DIV)
  ) u_tmr (
    .clk(clk),
    .system_reset_output(system_reset_output),
    .enable(wd_enable),
    .restart(s.wd_restart),
    .period_ms(period_ms),
    .overflow(wd_overflow)
  );

  // Event vector in rising priority from index 1: a later index wins a same-cycle tie; index 0 wins every tie
  assign ev[0] = por_event || ext_reset_event;
  assign ev[1] = cyclic_wake_event && is_sleep;
  assign ev[2] = v1_low_event;
  assign ev[3] = v1_overcurrent_event && (op_mode == ssr_pkg::OP_STANDBY)
    && wd_off && supply_current_reset_option;
  assign ev[4] = v3_overload_event && is_sleep;
  assign ev[5] = flash_exit_event;
  assign ev[6] = flash_ready_event;
  assign ev[7] = bus_wake_event;
  assign ev[8] = local_wake_event;
  assign ev[9] = failsafe_wake_event;
  assign ev[10] = wd_overflow;
  assign ev[11] = wd_init_miss_event;
  assign ev[12] = wd_early_event;
  assign ev[13] = spi_illegal_event;
  assign ev[14] = int_timeout_event;

  always_comb begin
    next_s = s;
    next_s.status_valid = 1'b0;
    next_s.wd_restart = 1'b0;

    // Status read; the cause field is not touched by the read itself
    if (frame_valid && hdr_ok) begin
      next_s.status_valid = 1'b1;
      next_s.status_word = {ssr_pkg::STATUS_TOP, s.cause, ssr_pkg::STATUS_LOW};
      if (!frame_data[ssr_pkg::RO_BIT]) begin
        next_s.mode_reg = frame_data[ssr_pkg::MODE_W-1:0];
        next_s.wd_restart = 1'b1;
      end
    end

    // Ascending scan: the last hit, the highest rank, wins a same-cycle tie
    for (int i = 0; i < ssr_pkg::N_EVT; i++) begin
      if (ev[i]) begin
        next_s.cause = ssr_pkg::CAUSE_CODE[i];
      end
    end
    // Power-on outranks all other sources, so it is applied last
    if (ev[ssr_pkg::EV_POR]) begin
      next_s.cause = ssr_pkg::RC_POWER_ON;
    end

    if (s.rst_cnt != '0) begin
      next_s.rst_cnt = s.rst_cnt - ssr_pkg::RST_CNT_W'(1);
    end
    if (wd_overflow) begin
      next_s.rst_cnt = ssr_pkg::RST_CNT_W'(RST_PULSE_CYC);
    end

    // Reset is pulled one cycle before the supply drops, so the supply only drops while reset is held
    case (s.sleep_st)
      ssr_pkg::SSR_SL_RUN: begin
        if (is_sleep) begin
          next_s.sleep_st = ssr_pkg::SSR_SL_RST;
        end
      end
      ssr_pkg::SSR_SL_RST: begin
        if (is_sleep) begin
          next_s.sleep_st = ssr_pkg::SSR_SL_OFF;
        end else begin
          next_s.sleep_st = ssr_pkg::SSR_SL_RUN;
          next_s.rst_cnt = ssr_pkg::RST_CNT_W'(RST_PULSE_CYC);
        end
      end
      ssr_pkg::SSR_SL_OFF: begin
        if (!is_sleep) begin
          // Wake-up: supply back first, reset released after a pulse
          next_s.sleep_st = ssr_pkg::SSR_SL_RUN;
          next_s.rst_cnt = ssr_pkg::RST_CNT_W'(RST_PULSE_CYC);
        end
      end
      default: begin
        next_s.sleep_st = ssr_pkg::SSR_SL_RUN;
      end
    endcase

    next_s.reset_n = (next_s.sleep_st == ssr_pkg::SSR_SL_RUN)
      && (next_s.rst_cnt == '0);
    next_s.supply = (next_s.sleep_st != ssr_pkg::SSR_SL_OFF);
  end

  always_ff @(posedge clk or negedge system_reset_output) begin
    if (!system_reset_output) begin
      s.mode_reg <= ssr_pkg::MODE_RESET;
      s.cause <= ssr_pkg::RC_POWER_ON;
      s.status_word <= '0;
      s.status_valid <= 1'b0;
      s.sleep_st <= ssr_pkg::SSR_SL_RUN;
      s.rst_cnt <= '0;
      s.reset_n <= 1'b0;
      s.supply <= 1'b1;
      s.wd_restart <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign status_word = s.status_word;
  assign status_valid = s.status_valid;
  assign nominal_period_code = s.mode_reg[ssr_pkg::NPC_HI:ssr_pkg::NPC_LO];
  assign reset_cause_code = s.cause;
  assign system_reset_output_n = s.reset_n;
  assign mcu_supply_output = s.supply;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!system_reset_output);

  sequence seq_status_req;
    frame_valid && hdr_ok;
  endsequence

  sequence seq_sleep_enter;
    !is_sleep ##1 is_sleep;
  endsequence

  a_status_answer: assert property (seq_status_req |=> status_valid)
    else $error("status frame not answered");

  a_answer_content: assert property (status_valid |->
    status_word[11:8] == $past(reset_cause_code) && status_word[15:12] == 4'h0
    && status_word[7:0] == 8'h00)
    else $error("status answer content wrong");

  a_ro_keeps_mode: assert property (seq_status_req and frame_data[ssr_pkg::RO_BIT]
    |=> $stable(nominal_period_code))
    else $error("read-only frame changed mode register");

  a_rw_loads_mode: assert property (seq_status_req and !frame_data[ssr_pkg::RO_BIT]
    |=> nominal_period_code == $past(frame_data[11:6]))
    else $error("mode register not written");

  a_no_reserved: assert property (reset_cause_code != ssr_pkg::RC_RESERVED)
    else $error("reserved cause code produced");

  a_por_cause: assert property (ev[ssr_pkg::EV_POR] |=> reset_cause_code == 4'h0)
    else $error("power-on cause not recorded");

  a_ovf_cause: assert property ((wd_overflow && ev[ssr_pkg::N_EVT-1:ssr_pkg::EV_WD_OVF+1] == '0
    && !ev[ssr_pkg::EV_POR]) |=> reset_cause_code == 4'hB)
    else $error("watchdog overflow cause not recorded");

  a_cause_holds: assert property (ev == '0 |=> $stable(reset_cause_code))
    else $error("cause changed without reset event");

  a_sleep_rst_low: assert property (seq_sleep_enter |=> !system_reset_output_n)
    else $error("reset not pulled on sleep entry");

  a_supply_order: assert property (seq_sleep_enter ##1 is_sleep
    |-> !system_reset_output_n && mcu_supply_output ##1 !mcu_supply_output)
    else $error("supply dropped before reset held");

  a_supply_reset: assert property (!mcu_supply_output |-> !system_reset_output_n)
    else $error("supply off while reset released");

  a_off_stops_wd: assert property (is_sleep && wd_off |=> !wd_overflow)
    else $error("watchdog running with off code in sleep");

  // A lone event must land its own code in the next cycle
  a_cyclic_cause: assert property (ev == 15'h0002 |=> reset_cause_code == 4'h1)
    else $error("cyclic wake cause not recorded");

  a_low_cause: assert property (ev == 15'h0004 |=> reset_cause_code == 4'h2)
    else $error("low supply cause not recorded");

  a_current_cause: assert property (ev == 15'h0008 |=> reset_cause_code == 4'h3)
    else $error("overcurrent cause not recorded");

  a_aux_cause: assert property (ev == 15'h0010 |=> reset_cause_code == 4'h4)
    else $error("auxiliary overload cause not recorded");

  a_flash_cause: assert property (ev == 15'h0040 |=> reset_cause_code == 4'h6)
    else $error("flash ready cause not recorded");

  a_wake_cause: assert property (ev == 15'h0100 |=> reset_cause_code == 4'h9)
    else $error("local wake cause not recorded");

  a_tie_rank: assert property (ev[ssr_pkg::N_EVT-1] && !ev[ssr_pkg::EV_POR] |=> reset_cause_code == 4'hF)
    else $error("top ranked cause lost a tie");

  a_idle_no_answer: assert property (!(frame_valid && hdr_ok) |=> !status_valid)
    else $error("answer without a status frame");

  a_ovf_pulls_reset: assert property (wd_overflow |=> !system_reset_output_n)
    else $error("watchdog overflow did not pull reset");
endmodule

// ==== ssr_pkg.sv ====
// Shared constants for the watchdog period and system status readback block
package ssr_pkg;

  // Serial frame layout
  localparam int FRAME_W = 16;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 14;
  localparam int RRS_BIT = 13;
  localparam int RO_BIT = 12;
  localparam int MODE_W = 12;
  localparam int NPC_HI = 11;
  localparam int NPC_LO = 6;
  localparam int CAUSE_W = 4;
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [11:0] MODE_RESET = 12'h000;
  localparam logic [3:0] STATUS_TOP = 4'h0;
  localparam logic [7:0] STATUS_LOW = 8'h00;

  // Operating modes as reported by the mode controller
  localparam logic [1:0] OP_NORMAL = 2'h0;
  localparam logic [1:0] OP_STANDBY = 2'h1;
  localparam logic [1:0] OP_FLASH = 2'h2;
  localparam logic [1:0] OP_SLEEP = 2'h3;

  // Reset cause codes by event index, in rising priority from index 1; index 0, power-on, outranks all
  localparam int N_EVT = 15;
  localparam logic [3:0] CAUSE_CODE [N_EVT] = '{
    4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8,
    4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  localparam logic [3:0] RC_POWER_ON = 4'h0;
  localparam logic [3:0] RC_RESERVED = 4'h7;
  localparam logic [3:0] RC_WD_OVERFLOW = 4'hB;
  localparam int EV_POR = 0;
  localparam int EV_WD_OVF = 10;

  // Nominal period table for the top prescaler setting, in ms; zero means off
  localparam logic [1:0] PRESCALE_TABLE = 2'h3;
  localparam int N_PER = 10;
  localparam int PER_W = 15;
  localparam logic [14:0] PER_OFF = 15'h0000;
  localparam logic [5:0] PER_CODE [N_PER] = '{
    6'h09, 6'h0C, 6'h12, 6'h14, 6'h1B, 6'h24, 6'h2D, 6'h33, 6'h35, 6'h36};
  localparam logic [14:0] PER_NORMAL [N_PER] = '{
    15'h000E, 15'h001C, 15'h0038, 15'h0070, 15'h008C,
    15'h00A8, 15'h00C4, 15'h00E0, 15'h00FC, 15'h0118};
  localparam logic [14:0] PER_STANDBY [N_PER] = '{
    15'h0046, 15'h008C, 15'h0118, 15'h0230, 15'h0460,
    15'h08C0, 15'h0E00, 15'h1C00, 15'h3800, 15'h0000};
  localparam logic [14:0] PER_FLASH [N_PER] = '{
    15'h0046, 15'h008C, 15'h0118, 15'h0230, 15'h0460,
    15'h08C0, 15'h0E00, 15'h1C00, 15'h3800, 15'h7000};
  localparam logic [14:0] PER_SLEEP [N_PER] = '{
    15'h0230, 15'h0460, 15'h08C0, 15'h0E00, 15'h1C00,
    15'h2A00, 15'h3800, 15'h5400, 15'h7000, 15'h0000};

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_FREQ_KHZ = 1000000 / CLK_PERIOD_NS;
  localparam int OSC_FREQ_KHZ = 512;
  localparam int OSC_DIV = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
  localparam int OSC_TICKS_PER_MS = OSC_FREQ_KHZ;
  localparam int CNT_W = 24;
  localparam int RST_PULSE_CYC = 16;
  localparam int RST_CNT_W = 8;

  // Sleep entry sequencer, one-hot
  typedef enum logic [2:0] {
    SSR_SL_RUN = 3'b001,
    SSR_SL_RST = 3'b010,
    SSR_SL_OFF = 3'b100
  } ssr_sleep_t;

endpackage

// ==== ssr_period_lut.sv ====
// Nominal watchdog period lookup by period code and operating mode
`timescale 1ns/10ps
module ssr_period_lut (
  input wire logic [5:0] code,
  input wire logic [1:0] op_mode,
  input wire logic [1:0] prescale,
  output logic [ssr_pkg::PER_W-1:0] period_ms,
  output logic known,
  output logic wd_off
);
  logic [ssr_pkg::N_PER-1:0] hit;
  logic [ssr_pkg::PER_W-1:0] val [ssr_pkg::N_PER];

  genvar g;
  generate
    for (g = 0; g < ssr_pkg::N_PER; g++) begin : g_ent
      assign hit[g] = (code == ssr_pkg::PER_CODE[g]);
      always_comb begin
        case (op_mode)
          ssr_pkg::OP_NORMAL: val[g] = ssr_pkg::PER_NORMAL[g];
          ssr_pkg::OP_STANDBY: val[g] = ssr_pkg::PER_STANDBY[g];
          ssr_pkg::OP_FLASH: val[g] = ssr_pkg::PER_FLASH[g];
          default: val[g] = ssr_pkg::PER_SLEEP[g];
        endcase
      end
    end
  endgenerate

  // Codes are exclusive, so an OR of the masked entries selects one
  always_comb begin
    period_ms = ssr_pkg::PER_OFF;
    for (int i = 0; i < ssr_pkg::N_PER; i++) begin
      if (hit[i]) begin
        period_ms = period_ms | val[i];
      end
    end
  end

  // Only the top prescaler row is held; other rows read as unknown
  assign known = (|hit) && (prescale == ssr_pkg::PRESCALE_TABLE);
  assign wd_off = known && (period_ms == ssr_pkg::PER_OFF);
endmodule

// ==== ssr_wd_timer.sv ====
// Watchdog period counter driven by a divided-down internal oscillator
`timescale 1ns/10ps
module ssr_wd_timer #(
  parameter int OSC_DIV = ssr_pkg::OSC_DIV
) (
  input wire logic clk,
  input wire logic system_reset_output,
  input wire logic enable,
  input wire logic restart,
  input wire logic [ssr_pkg::PER_W-1:0] period_ms,
  output logic overflow
);
  localparam int DIV_W = $clog2(OSC_DIV) + 1;
  localparam int CW = ssr_pkg::CNT_W;

  generate
    if (OSC_DIV < 2) begin : g_chk
      $error("OSC_DIV must be at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [CW-1:0] cnt;
    logic ovf;
  } ssr_tmr_t;

  ssr_tmr_t s;
  ssr_tmr_t next_s;
  logic [CW-1:0] limit;

  // Durations scale with the oscillator: count oscillator ticks, not ms
  assign limit = CW'(period_ms) * CW'(ssr_pkg::OSC_TICKS_PER_MS);

  always_comb begin
    next_s = s;
    next_s.ovf = 1'b0;
    if (!enable || restart) begin
      next_s.div = '0;
      next_s.cnt = '0;
    end else if (s.div == DIV_W'(OSC_DIV - 1)) begin
      next_s.div = '0;
      if (s.cnt + CW'(1) >= limit) begin
        next_s.cnt = '0;
        next_s.ovf = 1'b1;
      end else begin
        next_s.cnt = s.cnt + CW'(1);
      end
    end else begin
      next_s.div = s.div + DIV_W'(1);
    end
  end

  always_ff @(posedge clk or negedge system_reset_output) begin
    if (!system_reset_output) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign overflow = s.ovf;

  a_overflow_span: assert property (@(posedge clk) disable iff (!system_reset_output)
    s.ovf |-> ($past(s.cnt) == $past(limit) - CW'(1)))
    else $error("watchdog overflow before the full period");
endmodule

// ==== ssr_host_model.sv ====
// Host microcontroller model that presents complete serial frames to the status bank
`timescale 1ns/10ps
module ssr_host_model (
  input wire logic clk,
  output logic frame_valid,
  output logic [ssr_pkg::FRAME_W-1:0] frame_data
);
  initial begin
    frame_valid = 1'b0;
    frame_data = 16'hFFFF;
  end

  // One frame per call, held for one whole cycle, launched on the falling edge
  task automatic send(input logic [15:0] d);
    @(negedge clk);
    frame_valid = 1'b1;
    frame_data = d;
    @(negedge clk);
    frame_valid = 1'b0;
    // Released bus shows the inverse so a stale frame cannot be mistaken for a new one
    frame_data = ~d;
  endtask

  // Status read: address 00 and select bit clear, read-only bit as the caller wants
  task automatic status_frame(input logic ro, input logic [11:0] payload);
    send({ssr_pkg::ADDR_STATUS, 1'b0, ro, payload});
  endtask
endmodule

// ==== ssr_status_bank_tb.sv ====
// Self-checking testbench for the status readback and watchdog period block
`timescale 1ns/10ps
module ssr_status_bank_tb;
  localparam int DIV = 2;
  localparam int PULSE = 2;
  localparam int WD_CYC = 14 * 512 * DIV;
  localparam logic [3:0] EXP [15] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
    4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF};
  logic clk;
  logic system_reset_output;
  logic [14:0] ev;
  logic [1:0] op_mode;
  logic [1:0] pre;
  logic opt;
  logic frame_valid;
  logic [15:0] frame_data;
  logic [15:0] status_word;
  logic status_valid;
  logic [5:0] npc;
  logic [3:0] cause;
  logic rst_n;
  logic sup;
  int fail_count;
  int comparisons;

  ssr_host_model host (.clk(clk), .frame_valid(frame_valid), .frame_data(frame_data));

  ssr_status_bank #(.OSC_DIV(DIV), .RST_PULSE_CYC(PULSE)) dut (
    .clk(clk), .system_reset_output(system_reset_output), .frame_valid(frame_valid), .frame_data(frame_data),
    .op_mode(op_mode), .watchdog_prescale_select(pre), .supply_current_reset_option(opt),
    .por_event(ev[0]), .ext_reset_event(ev[1]), .cyclic_wake_event(ev[2]),
    .v1_low_event(ev[3]), .v1_overcurrent_event(ev[4]), .v3_overload_event(ev[5]),
    .flash_exit_event(ev[6]), .flash_ready_event(ev[7]), .bus_wake_event(ev[8]),
    .local_wake_event(ev[9]), .failsafe_wake_event(ev[10]), .wd_init_miss_event(ev[11]),
    .wd_early_event(ev[12]), .spi_illegal_event(ev[13]), .int_timeout_event(ev[14]),
    .status_word(status_word), .status_valid(status_valid), .nominal_period_code(npc),
    .reset_cause_code(cause), .system_reset_output_n(rst_n), .mcu_supply_output(sup));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Waits a few cycles for the answer, so a read that is refused shows as no answer
  task automatic rd(input logic ro, input logic [11:0] pl, output logic seen);
    host.status_frame(ro, pl);
    seen = 1'b0;
    for (int i = 0; i < 3 && seen !== 1'b1; i++) begin
      if (status_valid === 1'b1) begin
        seen = 1'b1;
      end else begin
        @(negedge clk);
      end
    end
  endtask

  task automatic set_mode(input logic [1:0] m);
    @(negedge clk);
    op_mode = m;
    repeat (PULSE + 4) @(negedge clk);
  endtask

  initial begin
    logic seen;
    int rlow;
    int slow;
    int n;
    system_reset_output = 1'b0;
    ev = '0;
    op_mode = ssr_pkg::OP_NORMAL;
    pre = ssr_pkg::PRESCALE_TABLE;
    opt = 1'b1;
    fail_count = 0;
    comparisons = 0;
    repeat (6) @(negedge clk);
    chk("reset_n in reset", 16'h0, rst_n);
    chk("supply in reset", 16'h1, sup);
    system_reset_output = 1'b1;
    repeat (2) @(negedge clk);
    chk("cause after reset", 16'h0, cause);
    $display("test reset done");

    rd(1'b0, 12'hD80, seen);
    chk("write answered", 16'h1, seen);
    chk("period code written", 16'h36, npc);
    for (int m = 0; m < 4; m++) begin
      set_mode(m[1:0]);
      rd(1'b1, 12'h240, seen);
      chk("read answered", 16'h1, seen);
      chk("status word", 16'h0000, status_word);
      chk("mode kept on read only", 16'h36, npc);
    end
    set_mode(ssr_pkg::OP_NORMAL);
    rd(1'b0, 12'h240, seen);
    host.send(16'h4D80);
    chk("wrong address unanswered", 16'h0, status_valid);
    chk("wrong address ignored", 16'h09, npc);
    host.send(16'h2D80);
    chk("select bit ignored", 16'h09, npc);
    rd(1'b0, 12'hD80, seen);
    $display("test frames done");

    @(negedge clk);
    ev = 15'h0880;
    @(negedge clk);
    chk("same-cycle tie", 16'hC, cause);
    ev = 15'h0034;
    @(negedge clk);
    ev = '0;
    chk("mode-bound causes refused", 16'hC, cause);
    $display("test ties done");

    // Overwritten in descending order so every step but the last changes the field
    for (int i = 14; i >= 0; i--) begin
      set_mode(i == 2 || i == 5 ? ssr_pkg::OP_SLEEP : i == 4 ? ssr_pkg::OP_STANDBY : ssr_pkg::OP_NORMAL);
      @(negedge clk);
      ev[i] = 1'b1;
      @(negedge clk);
      ev[i] = 1'b0;
      @(negedge clk);
      chk("cause code", EXP[i], cause);
      chk("never reserved", 16'h1, cause !== ssr_pkg::RC_RESERVED);
      rd(1'b1, 12'h000, seen);
      chk("cause kept after read", EXP[i], status_word[11:8]);
    end
    $display("test causes done");

    set_mode(ssr_pkg::OP_NORMAL);
    @(negedge clk);
    op_mode = ssr_pkg::OP_SLEEP;
    rlow = 99;
    slow = 99;
    for (int c = 0; c < 5; c++) begin
      @(negedge clk);
      if (rst_n === 1'b0 && rlow == 99) rlow = c;
      if (sup === 1'b0 && slow == 99) slow = c;
    end
    chk("reset before supply off", 16'h1, rlow < slow && slow < 5);
    set_mode(ssr_pkg::OP_NORMAL);
    chk("supply back", 16'h1, sup);
    $display("test sleep done");

    rd(1'b0, 12'h240, seen);
    repeat (WD_CYC - 60) @(negedge clk);
    chk("no early overflow", 16'h0, cause);
    n = 0;
    while (cause !== ssr_pkg::RC_WD_OVERFLOW && n < 120) begin
      @(negedge clk);
      n++;
    end
    chk("overflow cause", 16'hB, cause);
    chk("overflow resets host", 16'h0, rst_n);
    $display("test watchdog done");
    tally_and_finish();
  end

  initial begin
    repeat (WD_CYC + 20000) @(posedge clk);
    fail_count++;
    $display("BAD watchdog expected done seen timeout");
    tally_and_finish();
  end
endmodule
